//--- rtl/ppg_defines.vh
// Constants for the pulse generator control block: register offsets,
// field positions, reset values and mode encodings.
// Assumes inclusion by bare name from the design files.
`ifndef PPG_DEFINES_VH
`define PPG_DEFINES_VH

// Register byte offsets on APB
`define PPG_OFF_CTRL1      8'h00
`define PPG_OFF_CTRL2      8'h04
`define PPG_OFF_CTRL3      8'h08
`define PPG_OFF_PERIOD     8'h0C
`define PPG_OFF_DEAD1      8'h10
`define PPG_OFF_WIDTH1     8'h14
`define PPG_OFF_DEAD2      8'h18
`define PPG_OFF_WIDTH2     8'h1C
`define PPG_OFF_COUNT      8'h20

// First control register fields
`define PPG_C1_EDGE        0
`define PPG_C1_ACCEPT      1
`define PPG_C1_START_LO    2
`define PPG_C1_INIT1       4
`define PPG_C1_INIT2       5
// Second control register fields
`define PPG_C2_OE1         0
`define PPG_C2_OE2         1
`define PPG_C2_FILT_LO     2
// Third control register fields
`define PPG_C3_RUN         0
`define PPG_C3_STM_LO      1
`define PPG_C3_BUSY        3

// Reset values
`define PPG_RST_CTRL       6'h00
`define PPG_RST_DATA       10'h000

// Start modes
`define PPG_START_CMDCAP   2'h0
`define PPG_START_CMDTRG   2'h1
`define PPG_START_TRIG     2'h2

// Stop modes
`define PPG_STM_INIT       2'h0
`define PPG_STM_KEEP       2'h1
`define PPG_STM_ONCE       2'h2

// Filter selects
`define PPG_FILT_DIV4      2'h0
`define PPG_FILT_DIV2      2'h1
`define PPG_FILT_DIV1      2'h2
`define PPG_FILT_BYPASS    2'h3

// Consecutive equal samples needed, minus one
`define PPG_FILT_LAST      3'h4

`endif

//--- rtl/ppg_noise_filter.v
// Trigger pin synchroniser and digital noise canceller.
// Assumes a single clock pclk; trigger pin is asynchronous-safe via two flops.
`timescale 1ns/10ps
`default_nettype none
`include "ppg_defines.vh"

module ppg_noise_filter (
   // Clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // Trigger pin and selection
   input  wire       trig_in,
   input  wire [1:0] filter_select,
   // Filtered level
   output reg        trig_filt_ff
);

   reg       sync1_ff;
   reg       sync2_ff;
   reg [1:0] div_ff;
   reg [2:0] same_ff;
   reg       sample_en;

   // ******************************************
   // Synchroniser
   // ******************************************
   // Two-stage capture of the pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= trig_in;
         sync2_ff <= sync1_ff;
      end
   end

   // ******************************************
   // Sampling enable
   // ******************************************
   // Free-running divider for fc/4 and fc/2
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= div_ff + 2'h1;
      end
   end

   // Sample strobe per select
   always @* begin
      case (filter_select)
         `PPG_FILT_DIV4: sample_en = (div_ff == 2'h3);
         `PPG_FILT_DIV2: sample_en = div_ff[0];
         default:        sample_en = 1'b1;
      endcase
   end

   // ******************************************
   // Five-sample acceptance
   // ******************************************
   // New level taken after five equal samples
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         same_ff      <= 3'h0;
         trig_filt_ff <= 1'b0;
      end else if (filter_select == `PPG_FILT_BYPASS) begin
         same_ff      <= 3'h0;
         trig_filt_ff <= sync2_ff;
      end else if (sample_en) begin
         if (sync2_ff == trig_filt_ff) begin
            same_ff <= 3'h0;
         end else if (same_ff == `PPG_FILT_LAST) begin
            same_ff      <= 3'h0;
            trig_filt_ff <= sync2_ff;
         end else begin
            same_ff <= same_ff + 3'h1;
         end
      end
   end

endmodule
`default_nettype wire

//--- rtl/ppg_ctrl.v
// Pulse generator control: APB registers, trigger acceptance, stop modes,
// one-time and continuous output, output level and enable control.
// Assumes one clock pclk, asynchronous active-low presetn, zero-wait APB.
`timescale 1ns/10ps
`default_nettype none
`include "ppg_defines.vh"

module ppg_ctrl #(
   parameter CNT_W = 10
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Trigger pin
   input  wire        trigger_pin,
   // Pulse outputs
   output wire        pulse_out1,
   output wire        pulse_out1_oe,
   output wire        pulse_out2,
   output wire        pulse_out2_oe,
   // Period event
   output reg         period_interrupt
);

   // ******************************************
   // Declarations
   // ******************************************
   reg [5:0]       ctrl1_ff;
   reg [3:0]       ctrl2_ff;
   reg             run_ff;
   reg [1:0]       stm_ff;
   reg [CNT_W-1:0] period_ff;
   reg [CNT_W-1:0] dead1_ff;
   reg [CNT_W-1:0] width1_ff;
   reg [CNT_W-1:0] dead2_ff;
   reg [CNT_W-1:0] width2_ff;
   reg [CNT_W-1:0] cnt_ff;
   reg             cnt_on_ff;
   reg             pend_ff;
   reg             lvl1_ff;
   reg             lvl2_ff;
   reg             prev_stop_ff;
   wire            trig_filt;
   wire            acc;
   wire            wr;
   wire            wr3;
   wire            new_run;
   wire [1:0]      new_stm;
   wire [1:0]      start_mode;
   wire            edge_sel;
   wire            accept_mode;
   wire            init1;
   wire            init2;
   wire            oe1;
   wire            oe2;
   wire            stop_lvl;
   wire            start_edge;
   wire            outs_active;
   wire            gate;
   wire            trig_stop;
   wire            trig_start;
   wire            cmd_stop;
   wire            cmd_start;
   wire            cmd_runs;
   wire            period_end;
   wire            act1;
   wire            act2;
   wire            busy;

   // Extend a count to one bit more; zero stands for full scale
   function [CNT_W:0] full_scale;
      input [CNT_W-1:0] v;
      begin
         full_scale = (v == {CNT_W{1'b0}}) ? {1'b1, {CNT_W{1'b0}}} : {1'b0, v};
      end
   endfunction

   // Known register offset
   function addr_hit;
      input [7:0] a;
      begin
         addr_hit = (a == `PPG_OFF_CTRL1) || (a == `PPG_OFF_CTRL2) ||
                    (a == `PPG_OFF_CTRL3) || (a == `PPG_OFF_PERIOD) ||
                    (a == `PPG_OFF_DEAD1) || (a == `PPG_OFF_WIDTH1) ||
                    (a == `PPG_OFF_DEAD2) || (a == `PPG_OFF_WIDTH2) ||
                    (a == `PPG_OFF_COUNT);
      end
   endfunction

   // ******************************************
   // Trigger noise filter
   // ******************************************
   ppg_noise_filter u_filt (
      .pclk          (pclk),
      .presetn       (presetn),
      .trig_in       (trigger_pin),
      .filter_select (ctrl2_ff[`PPG_C2_FILT_LO+1:`PPG_C2_FILT_LO]),
      .trig_filt_ff  (trig_filt)
   );

   // ******************************************
   // APB access
   // ******************************************
   // Zero-wait slave, error on unmapped offset
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign pready  = 1'b1;
   assign pslverr = acc & ~addr_hit(paddr);
   assign wr3     = wr & (paddr == `PPG_OFF_CTRL3);
   assign new_run = pwdata[`PPG_C3_RUN];
   assign new_stm = pwdata[`PPG_C3_STM_LO+1:`PPG_C3_STM_LO];

   // Configuration registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_ff  <= `PPG_RST_CTRL;
         ctrl2_ff  <= 4'h0;
         period_ff <= `PPG_RST_DATA;
         dead1_ff  <= `PPG_RST_DATA;
         width1_ff <= `PPG_RST_DATA;
         dead2_ff  <= `PPG_RST_DATA;
         width2_ff <= `PPG_RST_DATA;
      end else if (wr) begin
         case (paddr)
            `PPG_OFF_CTRL1:  ctrl1_ff  <= pwdata[5:0];
            `PPG_OFF_CTRL2:  ctrl2_ff  <= pwdata[3:0];
            `PPG_OFF_PERIOD: period_ff <= pwdata[CNT_W-1:0];
            `PPG_OFF_DEAD1:  dead1_ff  <= pwdata[CNT_W-1:0];
            `PPG_OFF_WIDTH1: width1_ff <= pwdata[CNT_W-1:0];
            `PPG_OFF_DEAD2:  dead2_ff  <= pwdata[CNT_W-1:0];
            `PPG_OFF_WIDTH2: width2_ff <= pwdata[CNT_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Read data registered in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `PPG_OFF_CTRL1:  prdata <= {26'h0000000, ctrl1_ff};
            `PPG_OFF_CTRL2:  prdata <= {28'h0000000, ctrl2_ff};
            `PPG_OFF_CTRL3:  prdata <= {28'h0000000, busy, stm_ff, run_ff};
            `PPG_OFF_PERIOD: prdata <= {22'h000000, period_ff};
            `PPG_OFF_DEAD1:  prdata <= {22'h000000, dead1_ff};
            `PPG_OFF_WIDTH1: prdata <= {22'h000000, width1_ff};
            `PPG_OFF_DEAD2:  prdata <= {22'h000000, dead2_ff};
            `PPG_OFF_WIDTH2: prdata <= {22'h000000, width2_ff};
            `PPG_OFF_COUNT:  prdata <= {22'h000000, cnt_ff};
            default:         prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ******************************************
   // Field decode
   // ******************************************
   assign edge_sel    = ctrl1_ff[`PPG_C1_EDGE];
   assign accept_mode = ctrl1_ff[`PPG_C1_ACCEPT];
   assign start_mode  = ctrl1_ff[`PPG_C1_START_LO+1:`PPG_C1_START_LO];
   assign init1       = ctrl1_ff[`PPG_C1_INIT1];
   assign init2       = ctrl1_ff[`PPG_C1_INIT2];
   assign oe1         = ctrl2_ff[`PPG_C2_OE1];
   assign oe2         = ctrl2_ff[`PPG_C2_OE2];
   assign busy        = cnt_on_ff | pend_ff;

   // ******************************************
   // Trigger acceptance
   // ******************************************
   // Stop level and start edge from the filtered level only
   assign stop_lvl   = trig_filt ^ edge_sel;
   assign start_edge = prev_stop_ff & ~stop_lvl;

   // Active state counts only for enabled outputs
   assign outs_active = (oe1 & (lvl1_ff != init1)) |
                        (oe2 & (lvl2_ff != init2));

   // Pin triggers need a trigger start mode and a set run bit or a pending stop
   assign gate = (start_mode != `PPG_START_CMDCAP) & (run_ff | pend_ff) &
                 (~accept_mode | ~outs_active);

   // Stop level acts each cycle, so a held stop lands once outputs drop
   assign trig_stop  = gate & stop_lvl & busy;
   assign trig_start = gate & start_edge & run_ff & ~cnt_on_ff;

   // Previous stop level
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_stop_ff <= 1'b0;
      end else begin
         prev_stop_ff <= stop_lvl;
      end
   end

   // ******************************************
   // Command decode
   // ******************************************
   assign cmd_stop  = wr3 & ~new_run & (run_ff | pend_ff);
   assign cmd_start = wr3 & new_run;
   // Command starts counting in command modes only, and with trigger start not while the pin holds stop level
   assign cmd_runs  = (start_mode == `PPG_START_CMDCAP) |
                      ((start_mode == `PPG_START_CMDTRG) & ~stop_lvl);
   assign period_end = cnt_on_ff &
                       ({1'b0, cnt_ff} == full_scale(period_ff) - 1'b1);

   // Output windows from dead time to pulse width
   assign act1 = (cnt_ff >= dead1_ff) & ({1'b0, cnt_ff} < full_scale(width1_ff));
   assign act2 = (cnt_ff >= dead2_ff) & ({1'b0, cnt_ff} < full_scale(width2_ff));

   // Run bit and stop mode follow software writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= 1'b0;
         stm_ff <= `PPG_STM_INIT;
      end else if (wr3) begin
         run_ff <= new_run;
         stm_ff <= new_stm;
      end
   end

   // ******************************************
   // Counter and output levels
   // ******************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff           <= {CNT_W{1'b0}};
         cnt_on_ff        <= 1'b0;
         pend_ff          <= 1'b0;
         lvl1_ff          <= 1'b0;
         lvl2_ff          <= 1'b0;
         period_interrupt <= 1'b0;
      end else begin
         period_interrupt <= 1'b0;
         if (cmd_stop) begin
            case (new_stm)
               `PPG_STM_KEEP: begin
                  cnt_ff    <= {CNT_W{1'b0}};
                  cnt_on_ff <= 1'b0;
               end
               `PPG_STM_ONCE: begin
                  pend_ff <= cnt_on_ff & ~period_end;
                  if (period_end) begin                          // Request on last count ends now
                     period_interrupt <= 1'b1;
                     cnt_ff           <= {CNT_W{1'b0}};
                     cnt_on_ff        <= 1'b0;
                     lvl1_ff          <= init1;
                     lvl2_ff          <= init2;
                  end else if (cnt_on_ff) begin                  // Period keeps running
                     cnt_ff  <= cnt_ff + 1'b1;
                     lvl1_ff <= init1 ^ act1;
                     lvl2_ff <= init2 ^ act2;
                  end
               end
               default: begin
                  cnt_ff    <= {CNT_W{1'b0}};
                  cnt_on_ff <= 1'b0;
                  lvl1_ff   <= init1;
                  lvl2_ff   <= init2;
               end
            endcase
         end else if (cmd_start) begin
            // Fresh start from initial levels, command wins over trigger
            cnt_ff    <= {CNT_W{1'b0}};
            cnt_on_ff <= cmd_runs;
            pend_ff   <= 1'b0;
            lvl1_ff   <= init1;
            lvl2_ff   <= init2;
            period_interrupt <= cmd_runs;
         end else if (trig_stop) begin
            cnt_ff    <= {CNT_W{1'b0}};
            cnt_on_ff <= 1'b0;
            pend_ff   <= 1'b0;
            lvl1_ff   <= init1;
            lvl2_ff   <= init2;
         end else if (trig_start) begin
            cnt_ff    <= {CNT_W{1'b0}};
            cnt_on_ff <= 1'b1;
            lvl1_ff   <= init1;
            lvl2_ff   <= init2;
         end else if (period_end) begin
            period_interrupt <= 1'b1;
            cnt_ff           <= {CNT_W{1'b0}};
            if (pend_ff | (stm_ff == `PPG_STM_ONCE)) begin
               cnt_on_ff <= 1'b0;
               pend_ff   <= 1'b0;
               lvl1_ff   <= init1;
               lvl2_ff   <= init2;
            end else begin
               lvl1_ff <= init1;
               lvl2_ff <= init2;
            end
         end else if (cnt_on_ff) begin
            cnt_ff  <= cnt_ff + 1'b1;
            lvl1_ff <= init1 ^ act1;
            lvl2_ff <= init2 ^ act2;
         end
      end
   end

   // ******************************************
   // Pin drive
   // ******************************************
   // Disabled outputs release the pin to port logic
   assign pulse_out1    = lvl1_ff;
   assign pulse_out2    = lvl2_ff;
   assign pulse_out1_oe = oe1;
   assign pulse_out2_oe = oe2;

endmodule
`default_nettype wire

//--- sim/ppg_ctrl_checker.sv
// Concurrent checks on the pulse generator control block ports.
// Assumes binding to ppg_ctrl; shadows written controls from APB traffic.
`timescale 1ns/10ps
`default_nettype none
`include "ppg_defines.vh"
module ppg_ctrl_checker #(
   parameter CNT_W = 10
) (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins and event
   input wire logic        trigger_pin,
   input wire logic        pulse_out1,
   input wire logic        pulse_out1_oe,
   input wire logic        pulse_out2,
   input wire logic        pulse_out2_oe,
   input wire logic        period_interrupt
);
   // ***********************************************
   // Shadow state
   // ***********************************************
   logic        wr_acc, rd_set, cont_ok;
   logic        ini1_ff, ini2_ff, run_ff, seen_ff;
   logic [1:0]  stm_ff, start_ff;
   logic [9:0]  per_ff;
   logic [10:0] gap_ff;
   logic [2:0]  idle_ff;

   // Bus phases, continuous command-start state
   assign wr_acc  = psel && penable && pwrite;
   assign rd_set  = psel && !penable && !pwrite;
   assign cont_ok = run_ff && stm_ff != `PPG_STM_ONCE && start_ff == `PPG_START_CMDCAP;

   // Written controls, event gap and idle time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {ini1_ff, ini2_ff, run_ff, seen_ff, stm_ff, start_ff, per_ff} <= '0;
         gap_ff  <= 11'h000;
         idle_ff <= 3'h0;
      end else begin
         gap_ff  <= period_interrupt ? 11'h001 : gap_ff + 11'h001;
         seen_ff <= !wr_acc && (seen_ff || period_interrupt);
         if (run_ff || stm_ff == `PPG_STM_ONCE || wr_acc)
            idle_ff <= 3'h0;
         else if (idle_ff != 3'h7)
            idle_ff <= idle_ff + 3'h1;
         if (wr_acc && paddr == `PPG_OFF_CTRL1)
            {ini2_ff, ini1_ff, start_ff} <= pwdata[5:2];
         if (wr_acc && paddr == `PPG_OFF_CTRL3)
            {stm_ff, run_ff} <= pwdata[2:0];
         if (wr_acc && paddr == `PPG_OFF_PERIOD)
            per_ff <= pwdata[9:0];
      end
   end

   // ***********************************************
   // Properties
   // ***********************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_oe_follow;
      wr_acc && paddr == `PPG_OFF_CTRL2 |=>
         pulse_out1_oe == $past(pwdata[0]) && pulse_out2_oe == $past(pwdata[1]);
   endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("enable pin differs from control");

   property p_stop_init;
      wr_acc && paddr == `PPG_OFF_CTRL3 && pwdata[2:0] == 3'h0 |->
         ##[1:3] (pulse_out1 == ini1_ff && pulse_out2 == ini2_ff);
   endproperty
   a_stop_init: assert property (p_stop_init) else $error("outputs not at initial level");

   property p_stop_keep;
      wr_acc && paddr == `PPG_OFF_CTRL3 && pwdata[2:0] == 3'h2 |->
         ##3 ($stable(pulse_out1) && $stable(pulse_out2)) [*4];
   endproperty
   a_stop_keep: assert property (p_stop_keep) else $error("kept levels moved");

   property p_irq_pulse;
      period_interrupt |=> !period_interrupt;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("period event too long");

   property p_period_gap;
      period_interrupt && seen_ff && cont_ok |-> gap_ff == {per_ff == 10'h000, per_ff};
   endproperty
   a_period_gap: assert property (p_period_gap) else $error("period event spacing wrong");

   property p_idle_quiet;
      idle_ff == 3'h7 |-> !period_interrupt && $stable(pulse_out1) && $stable(pulse_out2);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("activity while stopped");

   property p_run_read;
      rd_set && paddr == `PPG_OFF_CTRL3 |=> prdata[2:0] == {stm_ff, run_ff};
   endproperty
   a_run_read: assert property (p_run_read) else $error("run or stop mode readback wrong");

   property p_busy_idle;
      rd_set && paddr == `PPG_OFF_CTRL3 && idle_ff == 3'h7 |=> !prdata[3];
   endproperty
   a_busy_idle: assert property (p_busy_idle) else $error("busy while stopped");

   // Main scenarios reached
   c_keep: cover property (wr_acc && paddr == `PPG_OFF_CTRL3 && pwdata[2:0] == 3'h2);
   c_gap: cover property (period_interrupt && seen_ff && cont_ok);
   c_err: cover property (psel && penable && pslverr);
endmodule

bind ppg_ctrl ppg_ctrl_checker #(.CNT_W(CNT_W)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .trigger_pin(trigger_pin), .pulse_out1(pulse_out1), .pulse_out1_oe(pulse_out1_oe),
   .pulse_out2(pulse_out2), .pulse_out2_oe(pulse_out2_oe), .period_interrupt(period_interrupt));
`default_nettype wire

//--- sim/ppg_trig_src.sv
// External trigger source model driving the trigger pin.
// Assumes the bench calls drive() from its main sequence, one clock.
`timescale 1ns/10ps
`default_nettype none
module ppg_trig_src (
   // Clock
   input  wire logic clk,
   // Trigger level
   output var  logic pin
);
   initial pin = 1'b1;

   // Hold a level whole clocks, never under two
   task automatic drive(input logic lvl, input int hold);
      int n;
      n = (hold < 2) ? 2 : hold;
      @(posedge clk);
      pin <= lvl;
      repeat (n - 1) @(posedge clk);
   endtask
endmodule
`default_nettype wire

//--- sim/tb_ppg_trigger_stop_noise_control.sv
// Self-checking bench for the pulse generator control block.
// Assumes zero-wait APB slave and the trigger source model.
`timescale 1ns/10ps
`default_nettype none
`include "ppg_defines.vh"
module tb_ppg_trigger_stop_noise_control;
   localparam logic [7:0] C1 = `PPG_OFF_CTRL1;
   localparam logic [7:0] C2 = `PPG_OFF_CTRL2;
   localparam logic [7:0] C3 = `PPG_OFF_CTRL3;
   localparam logic [7:0] PER = `PPG_OFF_PERIOD;
   localparam logic [7:0] CNT = `PPG_OFF_COUNT;
   logic        pclk, presetn, psel, penable, pwrite, rerr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, trigger_pin, pulse_out1, pulse_out1_oe;
   wire         pulse_out2, pulse_out2_oe, period_interrupt;
   int          num_errors = 0;
   int          n_tests = 0;
   int          irq_cnt = 0;
   int          hi_cnt = 0;
   int          h;
   int          rej[3] = '{16, 8, 4};
   int          acc[3] = '{20, 10, 5};

   ppg_ctrl #(.CNT_W(10)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigger_pin(trigger_pin), .pulse_out1(pulse_out1), .pulse_out1_oe(pulse_out1_oe),
      .pulse_out2(pulse_out2), .pulse_out2_oe(pulse_out2_oe), .period_interrupt(period_interrupt));
   ppg_trig_src i_src (.clk(pclk), .pin(trigger_pin));

   // 250 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Period events and active-high time of the first output
   always @(posedge pclk) begin
      if (period_interrupt === 1'b1) irq_cnt <= irq_cnt + 1;
      if (pulse_out1 === 1'b1) hi_cnt <= hi_cnt + 1;
   end

   // ***********************************************
   // Tasks
   // ***********************************************
   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr_en; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd & m);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog far beyond the expected fifteen hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      $display("[ERR] watchdog exp finish got hang");
      final_report;
   end

   // ***********************************************
   // Tests
   // ***********************************************
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, access kinds, unmapped place
      rdc(C3, 32'hFFFFFFFF, 32'h0, "ctrl3_rst");
      wr(C2, 32'h0000000F);
      rdc(C2, 32'hFFFFFFFF, 32'hF, "ctrl2_rw");
      chk("oe", 32'h3, {30'h0, pulse_out2_oe, pulse_out1_oe});
      wr(CNT, 32'h3);
      rdc(CNT, 32'hFFFFFFFF, 32'h0, "count_ro");
      rdc(8'h24, 32'hFFFFFFFF, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, rerr});
      $display("test registers done");
      // Continuous plain timer, period five
      wr(C2, 32'h0); wr(C1, 32'h0); wr(PER, 32'h5); wr(C3, 32'h1);
      idle(10); h = irq_cnt; idle(50);
      chk("irq_rate", 32'd10, irq_cnt - h);
      wr(C3, 32'h0);
      $display("test continuous done");
      // Polarity, stop keep, restart, stop init
      wr(C2, 32'h3); wr(C1, 32'h10); wr(PER, 32'd40); wr(`PPG_OFF_DEAD1, 32'd10);
      wr(`PPG_OFF_WIDTH1, 32'd30); wr(`PPG_OFF_DEAD2, 32'd10); wr(`PPG_OFF_WIDTH2, 32'd30);
      wr(C3, 32'h3); idle(15);
      chk("lvl_active", 32'h2, {30'h0, pulse_out2, pulse_out1});
      wr(C3, 32'h2); idle(5);
      chk("lvl_kept", 32'h2, {30'h0, pulse_out2, pulse_out1});
      wr(C3, 32'h3); idle(3);
      chk("lvl_restart", 32'h1, {30'h0, pulse_out2, pulse_out1});
      idle(15); wr(C3, 32'h0); idle(8);
      chk("lvl_init", 32'h1, {30'h0, pulse_out2, pulse_out1});
      rdc(CNT, 32'h3FF, 32'h0, "count_halt");
      rdc(C3, 32'hF, 32'h0, "stopped");
      $display("test stop modes done");
      // One-time command start, rewrite restarts
      wr(C2, 32'h0); wr(PER, 32'd8); wr(C3, 32'h5);
      rdc(C3, 32'h8, 32'h8, "busy_run");
      idle(20);
      rdc(C3, 32'hF, 32'h5, "run_kept");
      rdc(CNT, 32'h3FF, 32'h0, "once_end");
      h = irq_cnt; idle(20);
      chk("once_quiet", 32'h0, irq_cnt - h);
      wr(PER, 32'd200); wr(C3, 32'h1); idle(100); wr(C3, 32'h5);
      apb(1'b0, CNT, 32'h0);
      chk("rewrite_clear", 32'h1, {31'h0, rd[9:0] < 10'd10});
      idle(220);
      // Stop at period end
      wr(PER, 32'd40); wr(C3, 32'h1); idle(10); wr(C3, 32'h4);
      rdc(C3, 32'hF, 32'hC, "end_pending");
      idle(45);
      rdc(C3, 32'hF, 32'h4, "end_done");
      $display("test one-time done");
      // Edge select, stop level, accept mode 0, bypass
      wr(C2, 32'hC); wr(PER, 32'h0);
      for (int e = 0; e < 2; e++) begin
         wr(C3, 32'h0); i_src.drive(!e[0], 4); wr(C1, 32'h8 | e); wr(C3, 32'h1); idle(8);
         rdc(CNT, 32'h3FF, 32'h0, "held");
         i_src.drive(e[0], 20); apb(1'b0, CNT, 32'h0);
         chk("started", 32'h1, {31'h0, rd[9:0] != 10'h0});
         i_src.drive(!e[0], 10);
         rdc(CNT, 32'h3FF, 32'h0, "stop_taken");
      end
      wr(C3, 32'h0); i_src.drive(1'b1, 20);
      rdc(CNT, 32'h3FF, 32'h0, "run_off");
      // Command plus trigger start: runs off stop level, stop level clears
      wr(C1, 32'h5); wr(C3, 32'h1); idle(4); apb(1'b0, CNT, 32'h0);
      chk("cmd_started", 32'h1, {31'h0, rd[9:0] != 10'h0});
      i_src.drive(1'b0, 10);
      rdc(CNT, 32'h3FF, 32'h0, "cmd_trig_stop");
      wr(C3, 32'h1); idle(4);
      rdc(CNT, 32'h3FF, 32'h0, "cmd_held");
      // Accept mode 1: active output blocks, disabled does not
      wr(C3, 32'h0); i_src.drive(1'b0, 4); wr(C2, 32'hD); wr(C1, 32'hB);
      wr(`PPG_OFF_DEAD1, 32'h0); wr(`PPG_OFF_WIDTH1, 32'd60); wr(PER, 32'd100); wr(C3, 32'h1);
      i_src.drive(1'b1, 10); i_src.drive(1'b0, 10); apb(1'b0, CNT, 32'h0);
      chk("blocked", 32'h1, {31'h0, rd[9:0] != 10'h0});
      idle(70);
      rdc(CNT, 32'h3FF, 32'h0, "late_stop");
      wr(C3, 32'h0); wr(C2, 32'hC); wr(C3, 32'h1);
      i_src.drive(1'b1, 10); i_src.drive(1'b0, 10);
      rdc(CNT, 32'h3FF, 32'h0, "oe_off_taken");
      $display("test triggers done");
      // Noise limits for each filter rate
      wr(C3, 32'h0); wr(C1, 32'h9); wr(`PPG_OFF_WIDTH1, 32'h0); wr(PER, 32'h0);
      for (int s = 0; s < 3; s++) begin
         wr(C3, 32'h0); i_src.drive(1'b0, 30); wr(C2, 32'h1 | (s << 2)); wr(C3, 32'h1); idle(30);
         h = hi_cnt; i_src.drive(1'b1, rej[s]); i_src.drive(1'b0, 40);
         chk("noise_drop", 32'h0, hi_cnt - h);
         i_src.drive(1'b1, acc[s]); i_src.drive(1'b0, 40);
         chk("signal_kept", 32'h1, {31'h0, hi_cnt != h});
      end
      $display("test filter done");
      final_report;
   end

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
endmodule
`default_nettype wire
